// ---- include/lbsp_pkg.sv ----
// lbsp_pkg: register map, field layout and timing constants of the led segment pacing block
package lbsp_pkg;

  // ----------------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W      = 5;
  localparam logic [4:0]  OFS_CTRL    = 5'h00;
  localparam logic [4:0]  OFS_STAT    = 5'h04;
  localparam logic [4:0]  OFS_STEP    = 5'h0C;
  localparam logic [4:0]  OFS_INTRVL  = 5'h10;
  localparam logic [4:0]  OFS_SKEW    = 5'h14;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int FIELD_W         = 4;
  localparam int SEG_W           = 3;
  localparam int DUTY_W          = 8;
  localparam int SKEW_W          = 8;
  localparam int AMT_W           = 5;
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_SHAPE_BIT  = 1;
  localparam int CTRL_COMMIT_BIT = 2;
  localparam int CTRL_RES_LSB    = 3;
  localparam int CTRL_MODE_LSB   = 5;
  localparam int CTRL_CLKSEL_BIT = 7;
  localparam int CTRL_SYNC_BIT   = 8;
  localparam int CTRL_SLEEP_BIT  = 9;
  localparam int CTRL_USED_W     = 10;
  localparam int STAT_DUTY_LSB   = 0;
  localparam int STAT_SEG_LSB    = 8;
  localparam int STAT_FALL_BIT   = 11;
  localparam int STAT_OUT_BIT    = 12;
  localparam int STAT_SKEW_BIT   = 13;

  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_7 = 2'h1;
  localparam logic [1:0] RES_6 = 2'h2;

  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_ON      = 2'h1;
  localparam logic [1:0] MODE_BREATHE = 2'h2;

  localparam logic [7:0] DUTY_MAX8 = 8'hFF;
  localparam logic [7:0] DUTY_MAX7 = 8'h7F;
  localparam logic [7:0] DUTY_MAX6 = 8'h3F;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ   = 250_000_000;
  localparam int FAST_HZ  = 48_000_000;
  localparam int SLOW_HZ  = 32_768;
  localparam int FAST_DIV = CLK_HZ / FAST_HZ;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int DIV_W    = 16;

  typedef enum logic { lbsp_rising, lbsp_falling } lbsp_ramp_t;
  typedef enum logic { lbsp_idle, lbsp_waiting } lbsp_skew_st_t;

  function automatic logic [7:0] lbsp_duty_max(input logic [1:0] res);
    unique case (res)
      RES_7:   lbsp_duty_max = DUTY_MAX7;
      RES_6:   lbsp_duty_max = DUTY_MAX6;
      default: lbsp_duty_max = DUTY_MAX8;
    endcase
  endfunction

endpackage

// ---- logic/lbsp_seg_select.sv ----
// lbsp_seg_select: segment index and per-segment step and wait decode
`timescale 1ns/10ps
module lbsp_seg_select import lbsp_pkg::*; (
  input  wire logic               shape,
  input  wire logic               falling,
  input  wire logic [DUTY_W-1:0]  duty,
  input  wire logic [1:0]         res,
  input  wire logic [31:0]        step_reg,
  input  wire logic [31:0]        intv_reg,
  output logic      [SEG_W-1:0]   seg_index,
  output logic      [AMT_W-1:0]   step_amt,
  output logic      [AMT_W-1:0]   wait_periods
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic [FIELD_W-1:0] step_f;
  logic [FIELD_W-1:0] intv_f;

  always_comb begin
    if (shape) begin
      seg_index = {falling, duty[DUTY_W-1 -: 2]};
    end else begin
      seg_index = duty[DUTY_W-1 -: SEG_W];
    end
    step_f = step_reg[seg_index*FIELD_W +: FIELD_W];
    intv_f = intv_reg[seg_index*FIELD_W +: FIELD_W];
    unique case (res)
      RES_7:   step_amt = AMT_W'({2'h0, step_f[3:1]}) + 5'h01;
      RES_6:   step_amt = AMT_W'({3'h0, step_f[3:2]}) + 5'h01;
      default: step_amt = AMT_W'({1'h0, step_f}) + 5'h01;
    endcase
    wait_periods = AMT_W'({1'h0, intv_f}) + 5'h01;
  end

endmodule // lbsp_seg_select

// ---- logic/lbsp_skew_gate.sv ----
// lbsp_skew_gate: turn-on skew counter in ticks of the selected clock source
`timescale 1ns/10ps
module lbsp_skew_gate import lbsp_pkg::*; #(
  parameter int CNT_W = SKEW_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] skew_count,
  output logic                  busy
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  lbsp_skew_st_t    st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    if (start) begin
      // zero count never enters the wait, so no delay is added
      st_d  = (skew_count == '0) ? lbsp_idle : lbsp_waiting;
      cnt_d = skew_count;
    end else begin
      unique case (st_q)
        lbsp_idle: begin
        end
        lbsp_waiting: begin
          if (tick) begin
            cnt_d = cnt_q - CNT_W'(1);
            if (cnt_q <= CNT_W'(1)) begin
              st_d = lbsp_idle;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= lbsp_idle;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign busy = (st_q == lbsp_waiting);

endmodule // lbsp_skew_gate

// ---- logic/lbsp_top.sv ----
// lbsp_top: breathing led pwm with per-segment pacing, commit-on-period registers and skew
// Summary of operation
// - at each duty update, step by the 4-bit field picked by segment index
// - eight 4-bit interval fields give periods between duty updates per segment
// - symmetric: segment index is duty bits 7:5
// - asymmetric: index is falling flag over duty bits 7:6
// - step and interval writes go to holding copies, committed at period end, or at once while the pwm is stopped
// - reads of step and interval return the active copies
// - interval field n waits n+1 pwm periods
// - 8-bit resolution: step is field plus one, 1 to 16
// - 7-bit drops field lsb, 6-bit drops two lsbs: steps 1-8 and 1-4
// - 8-bit skew count gives pwm clock ticks waited before turning the output on
// - skew wait applies on enable, resume from sleep, and sync
// - skew counts ticks of the selected pwm clock source
// - zero skew count adds no delay
// - constant on or off modes ignore the skew
// - step, interval and skew fields reset to zero
`timescale 1ns/10ps
module lbsp_top import lbsp_pkg::*; #(
  parameter int FAST_DIV_P = FAST_DIV,
  parameter int SLOW_DIV_P = SLOW_DIV
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   led_out
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] apply_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // bus slave: one wait cycle, then the access completes
  // ----------------------------------------------------------------------
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic        req;
  logic        acc_wr;

  // registers
  logic [31:0]       ctrl_q, ctrl_d;
  logic [31:0]       step_hold_q, step_hold_d;
  logic [31:0]       step_act_q, step_act_d;
  logic [31:0]       intv_hold_q, intv_hold_d;
  logic [31:0]       intv_act_q, intv_act_d;
  logic [SKEW_W-1:0] skew_q, skew_d;
  logic              sync_q, sync_d;

  // engine
  logic [DIV_W-1:0]  div_q, div_d;
  logic [DUTY_W-1:0] pwm_q, pwm_d;
  logic [DUTY_W-1:0] duty_q, duty_d;
  lbsp_ramp_t        ramp_q, ramp_d;
  logic [AMT_W-1:0]  icnt_q, icnt_d;
  logic              en_prev_q, en_prev_d;
  logic              sleep_prev_q, sleep_prev_d;
  logic              led_q, led_d;

  logic              en, sleep, run, tick, period_end, skew_start, skew_busy;
  logic              en_rise, wake, sync_go;
  logic [1:0]        res, mode;
  logic [DUTY_W-1:0] dmax;
  logic [DIV_W-1:0]  div_last;
  logic [SEG_W-1:0]  seg_index;
  logic [AMT_W-1:0]  step_amt, wait_periods;
  logic [DUTY_W:0]   sum;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign acc_wr          = avs_write & ack_q;
  assign avs_readdata    = rdata_q;

  always_comb begin
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read & ~ack_q) begin
      unique case (avs_address)
        OFS_CTRL:   rdata_d = ctrl_q;
        // status is a snapshot: duty may move on the very next tick
        OFS_STAT: begin
          rdata_d = RST_WORD;
          rdata_d[STAT_DUTY_LSB +: DUTY_W] = duty_q;
          rdata_d[STAT_SEG_LSB +: SEG_W]   = seg_index;
          rdata_d[STAT_FALL_BIT]           = (ramp_q == lbsp_falling);
          rdata_d[STAT_OUT_BIT]            = led_q;
          rdata_d[STAT_SKEW_BIT]           = skew_busy;
        end
        OFS_STEP:   rdata_d = step_act_q;
        OFS_INTRVL: rdata_d = intv_act_q;
        OFS_SKEW:   rdata_d = {{(32-SKEW_W){1'b0}}, skew_q};
        default:    rdata_d = UNMAPPED_RD;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  assign en    = ctrl_q[CTRL_EN_BIT];
  assign sleep = ctrl_q[CTRL_SLEEP_BIT];
  assign res   = ctrl_q[CTRL_RES_LSB +: 2];
  assign mode  = ctrl_q[CTRL_MODE_LSB +: 2];
  assign run   = en & ~sleep;

  always_comb begin
    ctrl_d      = ctrl_q;
    step_hold_d = step_hold_q;
    intv_hold_d = intv_hold_q;
    step_act_d  = step_act_q;
    intv_act_d  = intv_act_q;
    skew_d      = skew_q;
    sync_d      = 1'b0;
    if (acc_wr) begin
      unique case (avs_address)
        OFS_CTRL: begin
          ctrl_d = apply_be(ctrl_q, avs_writedata, avs_byteenable);
          // sync is a strobe: it starts the skew wait and is never stored
          sync_d = avs_byteenable[1] & avs_writedata[CTRL_SYNC_BIT];
          ctrl_d[CTRL_SYNC_BIT] = 1'b0;
          ctrl_d[31:CTRL_USED_W] = '0;
        end
        OFS_STEP:   step_hold_d = apply_be(step_hold_q, avs_writedata, avs_byteenable);
        OFS_INTRVL: intv_hold_d = apply_be(intv_hold_q, avs_writedata, avs_byteenable);
        // skew is one byte wide, so only lane 0 can change it
        OFS_SKEW: begin
          if (avs_byteenable[0]) begin
            skew_d = avs_writedata[SKEW_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // a stopped pwm has no period end, so pending values commit at once
    if (ctrl_q[CTRL_COMMIT_BIT] & (period_end | ~run)) begin
      step_act_d = step_hold_q;
      intv_act_d = intv_hold_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q       <= 1'b0;
      rdata_q     <= RST_WORD;
      ctrl_q      <= RST_WORD;
      step_hold_q <= RST_WORD;
      step_act_q  <= RST_WORD;
      intv_hold_q <= RST_WORD;
      intv_act_q  <= RST_WORD;
      skew_q      <= '0;
      sync_q      <= 1'b0;
    end else begin
      ack_q       <= ack_d;
      rdata_q     <= rdata_d;
      ctrl_q      <= ctrl_d;
      step_hold_q <= step_hold_d;
      step_act_q  <= step_act_d;
      intv_hold_q <= intv_hold_d;
      intv_act_q  <= intv_act_d;
      skew_q      <= skew_d;
      sync_q      <= sync_d;
    end
  end

  // ----------------------------------------------------------------------
  // segment decode and skew
  // ----------------------------------------------------------------------
  lbsp_seg_select u_seg (
    .shape        (ctrl_q[CTRL_SHAPE_BIT]),
    .falling      (ramp_q == lbsp_falling),
    .duty         (duty_q),
    .res          (res),
    .step_reg     (step_act_q),
    .intv_reg     (intv_act_q),
    .seg_index    (seg_index),
    .step_amt     (step_amt),
    .wait_periods (wait_periods)
  );

  // each cause has its own wire, so a missed edge shows up on its own
  assign en_rise    = en & ~en_prev_q;
  assign wake       = run & sleep_prev_q & ~sleep;
  assign sync_go    = sync_q & en;
  assign skew_start = en_rise | wake | sync_go;

  lbsp_skew_gate #(.CNT_W(SKEW_W)) u_skew (
    .clk        (clk),
    .rst        (rst),
    .start      (skew_start),
    .tick       (tick),
    .skew_count (skew_q),
    .busy       (skew_busy)
  );

  // ----------------------------------------------------------------------
  // pwm clock divider, period counter and ramp
  // ----------------------------------------------------------------------
  assign div_last   = ctrl_q[CTRL_CLKSEL_BIT] ? DIV_W'(SLOW_DIV_P - 1) : DIV_W'(FAST_DIV_P - 1);
  // tick is the one-cycle enable that stands in for the selected pwm clock
  assign tick       = run & (div_q >= div_last);
  assign dmax       = lbsp_duty_max(res);
  assign period_end = tick & (pwm_q >= dmax);
  assign sum        = {1'b0, duty_q} + (DUTY_W+1)'(step_amt);

  always_comb begin
    div_d        = div_q;
    pwm_d        = pwm_q;
    duty_d       = duty_q;
    ramp_d       = ramp_q;
    icnt_d       = icnt_q;
    en_prev_d    = en;
    sleep_prev_d = sleep;
    // the divider restarts from zero on every run, so the first tick is a full interval late
    if (!run) begin
      div_d = '0;
    end else if (tick) begin
      div_d = '0;
      pwm_d = period_end ? '0 : pwm_q + DUTY_W'(1);
    end else begin
      div_d = div_q + DIV_W'(1);
    end
    if (period_end & (mode == MODE_BREATHE)) begin
      if (icnt_q <= AMT_W'(1)) begin
        // the wait comes from the segment the duty leaves, not the one it enters
        icnt_d = wait_periods;
        unique case (ramp_q)
          lbsp_rising: begin
            if (sum >= {1'b0, dmax}) begin
              duty_d = dmax;
              ramp_d = lbsp_falling;
            end else begin
              duty_d = sum[DUTY_W-1:0];
            end
          end
          lbsp_falling: begin
            if (duty_q <= DUTY_W'(step_amt)) begin
              duty_d = '0;
              ramp_d = lbsp_rising;
            end else begin
              duty_d = duty_q - DUTY_W'(step_amt);
            end
          end
        endcase
      end else begin
        icnt_d = icnt_q - AMT_W'(1);
      end
    end
    unique case (mode)
      MODE_ON:      led_d = run;
      MODE_BREATHE: led_d = run & ~skew_busy & (pwm_q < duty_q);
      default:      led_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q        <= '0;
      pwm_q        <= '0;
      duty_q       <= '0;
      ramp_q       <= lbsp_rising;
      icnt_q       <= '0;
      en_prev_q    <= 1'b0;
      sleep_prev_q <= 1'b0;
      led_q        <= 1'b0;
    end else begin
      div_q        <= div_d;
      pwm_q        <= pwm_d;
      duty_q       <= duty_d;
      ramp_q       <= ramp_d;
      icnt_q       <= icnt_d;
      en_prev_q    <= en_prev_d;
      sleep_prev_q <= sleep_prev_d;
      led_q        <= led_d;
    end
  end

  // ----------------------------------------------------------------------
  // led pin
  // ----------------------------------------------------------------------
  // a flip-flop drives the pin so decode glitches never reach the lamp
  assign led_out = led_q;

endmodule // lbsp_top

// ---- testbench/lbsp_top_props.sv ----
// lbsp_top_props: port assertions for lbsp_top
`timescale 1ns/10ps
module lbsp_props import lbsp_pkg::*; #(
  parameter int FAST_DIV_P = FAST_DIV,
  parameter int SLOW_DIV_P = SLOW_DIV
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              led_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the control word; full-lane writes assumed for control
  logic       req, rdone, run, on_m, off_m;
  logic [9:0] ctl_q, ctl_d;
  assign req   = avs_read | avs_write;
  assign rdone = avs_read & ~avs_waitrequest;
  assign run   = ctl_q[CTRL_EN_BIT] & ~ctl_q[CTRL_SLEEP_BIT];
  assign on_m  = run & (ctl_q[CTRL_MODE_LSB +: 2] == MODE_ON);
  assign off_m = run & (ctl_q[CTRL_MODE_LSB +: 2] == MODE_OFF);
  always_comb begin
    ctl_d = ctl_q;
    if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL) begin
      ctl_d = avs_writedata[9:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end
  sequence s_wait; req && avs_waitrequest; endsequence
  sequence s_done; req && !avs_waitrequest; endsequence
  bus_one_wait_a: assert property ($rose(req) |-> s_wait ##1 s_done)
    else $error("access did not take one wait cycle");
  idle_no_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("wait asserted while idle");
  unmapped_zero_a: assert property (rdone && avs_address == 5'h08 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_echo_a: assert property (rdone && avs_address == OFS_CTRL |->
    avs_readdata[31:10] == '0 && !avs_readdata[8] && avs_readdata[7:0] == ctl_q[7:0]
    && avs_readdata[9] == ctl_q[9]) else $error("control readback wrong");
  skew_width_a: assert property (rdone && avs_address == OFS_SKEW |->
    avs_readdata[31:8] == '0) else $error("skew upper bits not zero");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved without a read");
  dark_off_a: assert property ((!run || off_m)[*3] |-> !led_out)
    else $error("led lit while off or stopped");
  steady_on_a: assert property (on_m[*3] |-> led_out)
    else $error("led dark in constant on");
endmodule // lbsp_props
bind lbsp_top lbsp_props #(.FAST_DIV_P(FAST_DIV_P), .SLOW_DIV_P(SLOW_DIV_P)) u_props (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .led_out(led_out)
);

// ---- testbench/lbsp_led_watch.sv ----
// lbsp_led_watch: led at the pin, counts turn-on edges since reset
`timescale 1ns/10ps
module lbsp_led_watch (
  input wire logic clk,
  input wire logic rst,
  input wire logic led_out,
  output int       rise_cnt
);
  logic led_q;
  // the lamp only loads the pin; counting edges shows the pwm really toggles
  always @(posedge clk) begin
    led_q <= led_out;
    if (rst) rise_cnt <= 0;
    else if (led_out === 1'b1 && led_q === 1'b0) rise_cnt <= rise_cnt + 1;
  end
endmodule // lbsp_led_watch

// ---- testbench/lbsp_top_tb.sv ----
// lbsp_top_tb: register, breathing, skew and steady mode scenarios for lbsp_top
`timescale 1ns/10ps
module lbsp_top_tb import lbsp_pkg::*; ;
  localparam int FD = 2;
  localparam int SD = 4;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, wt, led;
  logic [4:0]  adr = '0;
  logic [3:0]  be = 4'hF;
  logic [31:0] wd = '0, rdat, q, v, c;
  logic [63:0] notes[$];
  logic [63:0] nt;
  logic [4:0]  ofs[5] = '{OFS_CTRL, OFS_STEP, OFS_INTRVL, OFS_SKEW, 5'h08};
  int          err_count = 0, num_checks = 0, cyc = 0, rise, seed = 32'h57e17f54;
  always #2 clk = ~clk;
  lbsp_top #(.FAST_DIV_P(FD), .SLOW_DIV_P(SD)) DUT (
    .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wt), .led_out(led)
  );
  lbsp_led_watch u_led (.clk(clk), .rst(rst), .led_out(led), .rise_cnt(rise));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end
  // read watcher: every completed read retires the oldest note, mask 0 means poll only
  always @(posedge clk) begin
    if (rd && wt === 1'b0) begin
      nt = notes.pop_front();
      if (nt[63:32] != '0) check(rdat & nt[63:32], nt[31:0]);
    end
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [63:0] n);
    if (!w) notes.push_back(n);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wt !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic w32(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, '0);
  endtask
  task automatic r32(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, '0, {m, e});
  endtask
  task automatic reset_dut();
    rst <= 1;
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] amt(input logic [3:0] f, input logic [1:0] r);
    amt = (r == RES_6) ? 8'(f[3:2]) + 8'h01 : (r == RES_7) ? 8'(f[3:1]) + 8'h01 : 8'(f) + 8'h01;
  endfunction
  function automatic logic [2:0] seg(input logic [7:0] d, input logic s);
    seg = s ? {1'b0, d[7:6]} : d[7:5];
  endfunction
  task automatic next_duty(inout logic [7:0] d);
    int k;
    k = 0;
    do begin
      r32(OFS_STAT, '0, '0);
      k++;
    end while (q[7:0] === d && k < 1000);
    d = q[7:0];
  endtask
  task automatic breathe(input logic [1:0] r, input logic s);
    logic [31:0] st;
    logic [7:0]  d, e;
    int          t0, per;
    st = 32'h0000_021F;
    per = (r == RES_6 ? 64 : r == RES_7 ? 128 : 256) * FD;
    reset_dut();
    // commit while stopped, so the first update already uses the new fields
    w32(OFS_CTRL, {25'h0, MODE_BREATHE, r, 1'b1, s, 1'b0});
    w32(OFS_STEP, st);
    w32(OFS_INTRVL, 32'h1111_1111);
    w32(OFS_CTRL, {25'h0, MODE_BREATHE, r, 1'b1, s, 1'b1});
    e = 0;
    d = 0;
    t0 = 0;
    for (int i = 0; i < 3; i++) begin
      e = e + amt(st[4 * seg(e, s) +: 4], r);
      next_duty(d);
      if (i == 2) check((cyc - t0 + per / 2) / per, 2);
      t0 = cyc;
      r32(OFS_STAT, 32'h7FF, {21'h0, seg(e, s), e});
    end
    check(rise > 0, 1);
  endtask
  // polls the busy flag; a 3-cycle poll grain plus tick phase sets the window
  task automatic skew_run(input logic [31:0] cw, input int s, input int dv);
    int t0, k;
    w32(OFS_CTRL, cw);
    t0 = cyc;
    k = 0;
    do begin
      r32(OFS_STAT, '0, '0);
      k++;
    end while (q[STAT_SKEW_BIT] === 1'b1 && k < 400);
    check(cyc - t0 >= s * dv - dv - 4 && cyc - t0 <= s * dv + 8, 1);
  endtask
  initial begin
    reset_dut();
    foreach (ofs[i]) r32(ofs[i], '1, RST_WORD);
    v = $random(seed);
    w32(OFS_STEP, v);
    w32(OFS_INTRVL, ~v);
    be <= 4'h1;
    w32(OFS_STEP, ~v);
    be <= 4'hF;
    r32(OFS_STEP, '1, RST_WORD);
    r32(OFS_INTRVL, '1, RST_WORD);
    w32(OFS_CTRL, 32'h4);
    r32(OFS_STEP, '1, {v[31:8], ~v[7:0]});
    r32(OFS_INTRVL, '1, ~v);
    w32(5'h08, v);
    r32(5'h08, '1, UNMAPPED_RD);
    w32(OFS_SKEW, v);
    r32(OFS_SKEW, '1, {24'h0, v[7:0]});
    $display("register test done");
    breathe(RES_8, 1'b0);
    breathe(RES_8, 1'b1);
    breathe(RES_7, 1'b0);
    breathe(RES_6, 1'b0);
    reset_dut();
    w32(OFS_CTRL, 32'h14);
    w32(OFS_STEP, '1);
    w32(OFS_INTRVL, '0);
    w32(OFS_CTRL, 32'h57);
    do begin
      r32(OFS_STAT, '0, '0);
    end while (q[STAT_FALL_BIT] !== 1'b1);
    r32(OFS_STAT, 32'hFFF, {20'h0, 1'b1, 3'h4, DUTY_MAX6});
    $display("breathing test done");
    reset_dut();
    w32(OFS_SKEW, 32'd20);
    for (int sel = 0; sel < 2; sel++) begin
      c = 32'h45 | (sel << 7);
      w32(OFS_CTRL, '0);
      skew_run(c, 20, sel ? SD : FD);
      skew_run(c | 32'h100, 20, sel ? SD : FD);
      r32(OFS_CTRL, '1, c);
      w32(OFS_CTRL, c | 32'h200);
      skew_run(c, 20, sel ? SD : FD);
    end
    w32(OFS_SKEW, '0);
    w32(OFS_CTRL, '0);
    skew_run(32'h45, 0, FD);
    $display("skew test done");
    w32(OFS_SKEW, 32'd200);
    w32(OFS_CTRL, '0);
    w32(OFS_CTRL, 32'h25);
    r32(OFS_STAT, 32'h1000, 32'h1000);
    w32(OFS_CTRL, 32'h05);
    r32(OFS_STAT, 32'h1000, '0);
    $display("steady mode test done");
    summarize();
  end
endmodule // lbsp_top_tb
